// ---- logic/sic_cache.sv ----
`timescale 1ns/100ps
// Functional notes
// [RL1] enable set: cache fills and serves fetches
// [RL2] enable clear: every fetch goes straight through
// [RL3] array of 1024 24-bit words, eight sectors
// [RL4] low seven address bits pick sector word
// [RL5] upper seventeen address bits form sector tag
// [RL6] compare fetch tag with every stored tag
// [RL7] per-word valid bit; hit needs tag and valid
// [RL8] eight valid banks totalling 2048 bits
// [RL9] burst enable: fetch up to four words
// [RL10] burst clear: fetch exactly one word
// [RL11] hit served on chip, no external access
// [RL12] debug shows tags, locks, lru, hit
// [RL13] debug reads valid bit of any location
// [RL14] extended mode byte is status bits 23..16
// [RL15] miss replaces lru unlocked sector, clears valids
module sic_cache
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // mode words
  input wire logic [sic_pkg::STAT_W-1:0] core_status,
  input wire logic [sic_pkg::CHIP_MODE_W-1:0] extended_chip_mode_byte,
  // core fetch
  input wire sic_pkg::sic_fetch_req_t fetch_req,
  output sic_pkg::sic_fetch_rsp_t fetch_rsp,
  output logic fetch_busy,
  // external program memory
  output sic_pkg::sic_ext_req_t ext_req,
  input wire sic_pkg::sic_ext_rsp_t ext_rsp,
  // debug port
  input wire logic dbg_mode,
  input wire logic [sic_pkg::NUM_SECT-1:0] dbg_lock,
  input wire logic [sic_pkg::SECT_W-1:0] dbg_sect,
  input wire logic [sic_pkg::VBANK_W-1:0] dbg_word,
  output sic_pkg::sic_dbg_t dbg
);

  // ==========================================================
  // state
  typedef struct packed {
    sic_pkg::sic_state_t st;
    logic [sic_pkg::NUM_SECT*sic_pkg::TAG_W-1:0] tags;
    logic [sic_pkg::NUM_SECT-1:0] mapped;
    logic [sic_pkg::NUM_SECT*sic_pkg::SECT_W-1:0] age;
    logic [sic_pkg::NUM_SECT*sic_pkg::VBANK_BITS-1:0] vbits; // [RL8]
    logic [sic_pkg::ADDR_W-1:0] want;
    logic [sic_pkg::ADDR_W-1:0] fill_addr;
    logic [sic_pkg::SECT_W-1:0] fill_sect;
    logic [1:0] left;
    logic first;
    sic_pkg::sic_fetch_rsp_t rsp;
    sic_pkg::sic_ext_req_t ext;
    logic busy;
    sic_pkg::sic_dbg_t dbg;
  } sic_state_rec_t;

  sic_state_rec_t s_q;
  sic_state_rec_t s_d;

  // program words; held apart from the state record to map onto ram
  logic [sic_pkg::WORD_W-1:0] internal_program_ram [sic_pkg::ARRAY_WORDS]; // [RL3]
  logic ram_we;
  logic [9:0] ram_wa;
  logic [sic_pkg::WORD_W-1:0] ram_rd;

  // ==========================================================
  // decode
  logic [sic_pkg::EXT_MODE_W-1:0] extended_mode_byte;
  logic cache_en;
  logic burst_fetch_enable;
  logic [sic_pkg::TAG_W-1:0] req_tag;
  logic [sic_pkg::DISP_W-1:0] req_disp;
  logic match;
  logic [sic_pkg::SECT_W-1:0] msect;
  logic vfound;
  logic [sic_pkg::SECT_W-1:0] vsect;
  logic hit;

  assign extended_mode_byte = core_status[sic_pkg::EXT_MODE_LSB +: sic_pkg::EXT_MODE_W]; // [RL14]
  assign cache_en = extended_mode_byte[sic_pkg::CACHE_EN_BIT-sic_pkg::EXT_MODE_LSB];
  assign burst_fetch_enable = extended_chip_mode_byte[sic_pkg::BURST_EN_BIT];
  assign req_disp = fetch_req.addr[sic_pkg::DISP_W-1:0]; // [RL4]
  assign req_tag = fetch_req.addr[sic_pkg::ADDR_W-1 -: sic_pkg::TAG_W]; // [RL5]

  sic_tag_match u_match
  (
    .tag(req_tag),
    .tags(s_q.tags),
    .mapped(s_q.mapped),
    .match(match),
    .sect(msect)
  );

  sic_victim u_victim
  (
    .age(s_q.age),
    .locked(dbg_lock),
    .found(vfound),
    .sect(vsect)
  );

  assign hit = match && s_q.vbits[{msect, 1'b0, req_disp}]; // [RL7]

  always_ff @(posedge sys_clk)
  begin
    if (ram_we)
      internal_program_ram[ram_wa] <= ext_rsp.data;
    ram_rd <= internal_program_ram[{msect, req_disp}];
  end

  // ==========================================================
  // next state
  always_comb
  begin
    logic [sic_pkg::SECT_W-1:0] touch;
    logic do_touch;
    logic [sic_pkg::SECT_W-1:0] old;
    touch = '0;
    do_touch = 1'b0;
    old = '0;
    s_d = s_q;
    ram_we = 1'b0;
    ram_wa = {s_q.fill_sect, s_q.fill_addr[sic_pkg::DISP_W-1:0]};
    s_d.rsp.valid = 1'b0;
    s_d.dbg.hit = 1'b0;
    case (s_q.st)
      sic_pkg::SIC_IDLE:
      begin
        s_d.busy = 1'b0;
        if (fetch_req.req && !s_q.busy)
        begin
          s_d.want = fetch_req.addr;
          s_d.busy = 1'b1;
          if (!cache_en)
          begin
            s_d.ext.req = 1'b1; // [RL2]
            s_d.ext.addr = fetch_req.addr;
            s_d.st = sic_pkg::SIC_BYP;
          end
          else if (hit)
          begin
            s_d.st = sic_pkg::SIC_WAIT; // [RL11]
            touch = msect;
            do_touch = 1'b1;
          end
          else if (match || vfound)
          begin
            s_d.fill_sect = match ? msect : vsect;
            if (!match)
            begin
              s_d.tags[vsect*sic_pkg::TAG_W +: sic_pkg::TAG_W] = req_tag; // [RL15]
              s_d.mapped[vsect] = 1'b1;
              s_d.vbits[vsect*sic_pkg::VBANK_BITS +: sic_pkg::VBANK_BITS] = '0;
            end
            s_d.fill_addr = fetch_req.addr;
            s_d.left = burst_fetch_enable ? 2'(sic_pkg::BURST_MAX - 1 - 32'(req_disp[1:0])) : 2'h0; // [RL9] [RL10]
            s_d.first = 1'b1;
            s_d.ext.req = 1'b1;
            s_d.ext.addr = fetch_req.addr;
            s_d.st = sic_pkg::SIC_FILL;
            touch = match ? msect : vsect;
            do_touch = 1'b1;
          end
          else
          begin
            // every sector locked: serve uncached
            s_d.ext.req = 1'b1;
            s_d.ext.addr = fetch_req.addr;
            s_d.st = sic_pkg::SIC_BYP;
          end
        end
      end
      sic_pkg::SIC_FILL:
      begin
        s_d.ext.req = 1'b0;
        if (ext_rsp.valid)
        begin
          ram_we = 1'b1; // [RL1]
          s_d.vbits[{s_q.fill_sect, 1'b0, s_q.fill_addr[sic_pkg::DISP_W-1:0]}] = 1'b1; // [RL7]
          if (s_q.first)
          begin
            s_d.rsp.valid = 1'b1;
            s_d.rsp.data = ext_rsp.data;
            s_d.first = 1'b0;
          end
          if (s_q.left == 2'h0)
          begin
            s_d.st = sic_pkg::SIC_IDLE;
            s_d.busy = 1'b0;
          end
          else
          begin
            s_d.left = s_q.left - 2'h1; // [RL9]
            s_d.fill_addr = s_q.fill_addr + 24'h000001;
            s_d.ext.req = 1'b1;
            s_d.ext.addr = s_q.fill_addr + 24'h000001;
          end
        end
      end
      sic_pkg::SIC_WAIT:
      begin
        s_d.rsp.valid = 1'b1; // [RL1]
        s_d.rsp.data = ram_rd;
        // hit flag lines up with the word it served
        s_d.dbg.hit = 1'b1; // [RL12]
        s_d.busy = 1'b0;
        s_d.st = sic_pkg::SIC_IDLE;
      end
      sic_pkg::SIC_BYP:
      begin
        s_d.ext.req = 1'b0;
        if (ext_rsp.valid)
        begin
          s_d.rsp.valid = 1'b1;
          s_d.rsp.data = ext_rsp.data;
          s_d.busy = 1'b0;
          s_d.st = sic_pkg::SIC_IDLE;
        end
      end
      default:
      begin
        s_d.st = sic_pkg::SIC_IDLE;
      end
    endcase
    // age counters: used sector to zero, younger ones step up
    if (do_touch)
    begin
      old = s_q.age[touch*sic_pkg::SECT_W +: sic_pkg::SECT_W];
      for (int i = 0; i < sic_pkg::NUM_SECT; i++)
      begin
        if (s_q.age[i*sic_pkg::SECT_W +: sic_pkg::SECT_W] < old)
          s_d.age[i*sic_pkg::SECT_W +: sic_pkg::SECT_W] = s_q.age[i*sic_pkg::SECT_W +: sic_pkg::SECT_W] + 3'h1;
      end
      s_d.age[touch*sic_pkg::SECT_W +: sic_pkg::SECT_W] = '0;
    end
    // debug view: outside debug mode hit is held low and the rest is frozen
    if (dbg_mode)
    begin
      s_d.dbg.tags = s_q.tags; // [RL12]
      s_d.dbg.mapped = s_q.mapped;
      s_d.dbg.locked = dbg_lock;
      s_d.dbg.lru = vsect;
      s_d.dbg.vbit = s_q.vbits[{dbg_sect, dbg_word}]; // [RL13]
    end
    else
    begin
      s_d.dbg.hit = 1'b0;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s_q <= '0;
      for (int i = 0; i < sic_pkg::NUM_SECT; i++)
      begin
        s_q.tags[i*sic_pkg::TAG_W +: sic_pkg::TAG_W] <= sic_pkg::TAG_RST;
        // distinct ages keep the recency order a permutation
        s_q.age[i*sic_pkg::SECT_W +: sic_pkg::SECT_W] <= 3'(sic_pkg::NUM_SECT - 1 - i);
      end
      s_q.dbg.lru <= sic_pkg::LRU_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign fetch_rsp = s_q.rsp;
  assign fetch_busy = s_q.busy;
  assign ext_req = s_q.ext;
  assign dbg = s_q.dbg;

endmodule : sic_cache

// ---- logic/sic_pkg.sv ----
package sic_pkg;

  // ==========================================================
  // address split and array shape
  localparam int ADDR_W = 24;
  localparam int WORD_W = 24;
  localparam int DISP_W = 7;
  localparam int TAG_W = 17;
  localparam int NUM_SECT = 8;
  localparam int SECT_W = 3;
  localparam int SECT_WORDS = 128;
  localparam int ARRAY_WORDS = 1024;
  localparam int VBANK_BITS = 256;
  localparam int VBANK_W = 8;
  localparam int BURST_MAX = 4;

  // ==========================================================
  // status word and chip mode byte field positions
  localparam int STAT_W = 24;
  localparam int EXT_MODE_LSB = 16;
  localparam int EXT_MODE_W = 8;
  localparam int CACHE_EN_BIT = 19;
  localparam int CHIP_MODE_W = 8;
  localparam int BURST_EN_BIT = 2;

  // ==========================================================
  // reset values
  localparam logic [TAG_W-1:0] TAG_RST = 17'h00000;
  localparam logic [SECT_W-1:0] LRU_RST = 3'h0;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic req;
    logic [ADDR_W-1:0] addr;
  } sic_fetch_req_t;

  typedef struct packed {
    logic valid;
    logic [WORD_W-1:0] data;
  } sic_fetch_rsp_t;

  typedef struct packed {
    logic req;
    logic [ADDR_W-1:0] addr;
  } sic_ext_req_t;

  typedef struct packed {
    logic valid;
    logic [WORD_W-1:0] data;
  } sic_ext_rsp_t;

  typedef struct packed {
    logic [NUM_SECT*TAG_W-1:0] tags;
    logic [NUM_SECT-1:0] mapped;
    logic [NUM_SECT-1:0] locked;
    logic [SECT_W-1:0] lru;
    logic hit;
    logic vbit;
  } sic_dbg_t;

  typedef enum logic [1:0] {
    SIC_IDLE = 2'b00,
    SIC_FILL = 2'b01,
    SIC_WAIT = 2'b11,
    SIC_BYP = 2'b10
  } sic_state_t;

endpackage : sic_pkg

// ---- logic/sic_tag_match.sv ----
`timescale 1ns/100ps
module sic_tag_match
(
  // lookup
  input wire logic [sic_pkg::TAG_W-1:0] tag,
  input wire logic [sic_pkg::NUM_SECT*sic_pkg::TAG_W-1:0] tags,
  input wire logic [sic_pkg::NUM_SECT-1:0] mapped,
  // result
  output logic match,
  output logic [sic_pkg::SECT_W-1:0] sect
);

  logic [sic_pkg::NUM_SECT-1:0] eq;

  // ==========================================================
  // compare
  genvar g;
  generate
    for (g = 0; g < sic_pkg::NUM_SECT; g++)
    begin : g_cmp
      assign eq[g] = mapped[g] && (tags[g*sic_pkg::TAG_W +: sic_pkg::TAG_W] == tag); // [RL6]
    end
  endgenerate

  always_comb
  begin
    match = |eq;
    sect = '0;
    for (int i = 0; i < sic_pkg::NUM_SECT; i++)
    begin
      if (eq[i])
        sect = i[sic_pkg::SECT_W-1:0];
    end
  end

endmodule : sic_tag_match

// ---- logic/sic_victim.sv ----
`timescale 1ns/100ps
module sic_victim
(
  // sector usage
  input wire logic [sic_pkg::NUM_SECT*sic_pkg::SECT_W-1:0] age,
  input wire logic [sic_pkg::NUM_SECT-1:0] locked,
  // choice
  output logic found,
  output logic [sic_pkg::SECT_W-1:0] sect
);

  // ==========================================================
  // oldest unlocked sector (largest age)
  always_comb
  begin
    logic [sic_pkg::SECT_W-1:0] best;
    best = '0;
    found = 1'b0;
    sect = '0;
    for (int i = 0; i < sic_pkg::NUM_SECT; i++)
    begin
      if (!locked[i] && (!found || age[i*sic_pkg::SECT_W +: sic_pkg::SECT_W] >= best))
      begin
        found = 1'b1;
        best = age[i*sic_pkg::SECT_W +: sic_pkg::SECT_W];
        sect = i[sic_pkg::SECT_W-1:0];
      end
    end
  end

endmodule : sic_victim

// ---- verification/sic_cache_chk.sv ----
`timescale 1ns/100ps
module sic_cache_chk
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // mode words
  input wire logic [23:0] core_status,
  input wire logic [7:0] extended_chip_mode_byte,
  // core fetch
  input wire sic_pkg::sic_fetch_req_t fetch_req,
  input wire sic_pkg::sic_fetch_rsp_t fetch_rsp,
  input wire logic fetch_busy,
  // external memory
  input wire sic_pkg::sic_ext_req_t ext_req,
  input wire sic_pkg::sic_ext_rsp_t ext_rsp,
  // debug port
  input wire logic dbg_mode,
  input wire logic [7:0] dbg_lock,
  input wire logic [2:0] dbg_sect,
  input wire logic [7:0] dbg_word,
  input wire sic_pkg::sic_dbg_t dbg
);
  // ==========================================
  // tracking, conservative about accept edges
  logic take;
  logic pend_q;
  logic rv_q;
  logic fb_q;
  logic [23:0] ea_q;
  assign take = fetch_req.req && !fetch_busy && !fb_q && !rv_q && !pend_q;
  always_ff @(posedge sys_clk)
  begin
    rv_q <= !rst && fetch_rsp.valid;
    fb_q <= !rst && fetch_busy;
    pend_q <= !rst && (take || (pend_q && !fetch_rsp.valid));
    if (ext_req.req)
      ea_q <= ext_req.addr;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_BYPASS: assert property (take && !core_status[19] |=> ext_req.req)
    else $error("bypass fetch not sent out");
  AST_HIT_LAT: assert property (take ##1 !ext_req.req |=> fetch_rsp.valid)
    else $error("on-chip fetch late");
  AST_ONE_WORD: assert property (!extended_chip_mode_byte[2] && ext_rsp.valid |=> !ext_req.req)
    else $error("extra word fetched");
  AST_BURST_SEQ: assert property (ext_req.req && $past(ext_rsp.valid) |->
    ext_req.addr == ea_q + 24'h1 && ext_req.addr[1:0] != 2'h0)
    else $error("burst address wrong");
  AST_BURST_MORE: assert property (extended_chip_mode_byte[2] && core_status[19] && !(&dbg_lock)
    && ext_rsp.valid && ea_q[1:0] != 2'h3 |=> ext_req.req)
    else $error("burst ended early");
  AST_MISS_RSP: assert property (pend_q && ext_rsp.valid |=>
    fetch_rsp.valid && fetch_rsp.data == $past(ext_rsp.data))
    else $error("fetched word not returned");
  AST_NO_STRAY: assert property (fetch_rsp.valid |-> pend_q)
    else $error("unrequested response");
  AST_DBG_LOCK: assert property ($past(dbg_mode) && !$past(rst) |-> dbg.locked == $past(dbg_lock))
    else $error("lock view wrong");
  AST_HIT_ONCHIP: assert property (dbg.hit |-> fetch_rsp.valid && $past(ext_req.req) == 1'b0)
    else $error("hit used the bus");
  AST_EXT_PULSE: assert property (ext_req.req |=> !ext_req.req)
    else $error("request not a pulse");
endmodule : sic_cache_chk

bind sic_cache sic_cache_chk i_sic_cache_chk (.sys_clk(sys_clk), .rst(rst), .core_status(core_status),
  .extended_chip_mode_byte(extended_chip_mode_byte), .fetch_req(fetch_req), .fetch_rsp(fetch_rsp),
  .fetch_busy(fetch_busy), .ext_req(ext_req), .ext_rsp(ext_rsp), .dbg_mode(dbg_mode),
  .dbg_lock(dbg_lock), .dbg_sect(dbg_sect), .dbg_word(dbg_word), .dbg(dbg));

// ---- verification/sic_ext_mem.sv ----
`timescale 1ns/100ps
module sic_ext_mem
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // memory port
  input wire sic_pkg::sic_ext_req_t ext_req,
  output sic_pkg::sic_ext_rsp_t ext_rsp
);
  // ==========================================
  // alternates quick and slow replies; data inverts when idle
  logic [23:0] a_q;
  logic [1:0] cnt_q;
  logic busy_q;
  logic slow_q;
  always_ff @(posedge sys_clk)
  begin
    ext_rsp.valid <= 1'b0;
    ext_rsp.data <= ~ext_rsp.data;
    if (rst)
    begin
      busy_q <= 1'b0;
      slow_q <= 1'b0;
      ext_rsp.data <= 24'h0;
    end
    else if (ext_req.req)
    begin
      busy_q <= 1'b1;
      a_q <= ext_req.addr;
      cnt_q <= slow_q ? 2'h2 : 2'h0;
      slow_q <= ~slow_q;
    end
    else if (busy_q)
    begin
      if (cnt_q == 2'h0)
      begin
        busy_q <= 1'b0;
        ext_rsp.valid <= 1'b1;
        ext_rsp.data <= a_q ^ 24'ha5c3e1;
      end
      cnt_q <= cnt_q - 2'h1;
    end
  end
endmodule : sic_ext_mem

// ---- verification/sic_cache_tb_top.sv ----
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; $display("ERROR %0t mismatch", $time); end end
module sic_cache_tb_top;
  // ==========================================
  // stimulus and counters
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [23:0] core_status = 24'h0;
  logic [7:0] chip_mode = 8'h0;
  sic_pkg::sic_fetch_req_t fetch_req = '0;
  sic_pkg::sic_fetch_rsp_t fetch_rsp;
  logic fetch_busy;
  sic_pkg::sic_ext_req_t ext_req;
  sic_pkg::sic_ext_rsp_t ext_rsp;
  logic dbg_mode = 1'b0;
  logic [7:0] dbg_lock = 8'h0;
  logic [2:0] dbg_sect = 3'h0;
  logic [7:0] dbg_word = 8'h0;
  sic_pkg::sic_dbg_t dbg;
  int n_errors = 0;
  int n_checks = 0;
  int n_ext = 0;
  int n_hit = 0;
  int sect_a = 0;
  always #20 sys_clk = ~sys_clk;
  // mid-cycle counting keeps clear of edge races
  always @(negedge sys_clk)
  begin
    if (ext_req.req === 1'b1)
      n_ext++;
    if (dbg.hit === 1'b1)
      n_hit++;
  end
  sic_cache i_sic_cache (.sys_clk(sys_clk), .rst(rst), .core_status(core_status),
    .extended_chip_mode_byte(chip_mode), .fetch_req(fetch_req), .fetch_rsp(fetch_rsp),
    .fetch_busy(fetch_busy), .ext_req(ext_req), .ext_rsp(ext_rsp), .dbg_mode(dbg_mode),
    .dbg_lock(dbg_lock), .dbg_sect(dbg_sect), .dbg_word(dbg_word), .dbg(dbg));
  sic_ext_mem i_sic_ext_mem (.sys_clk(sys_clk), .rst(rst), .ext_req(ext_req), .ext_rsp(ext_rsp));
  task automatic finish_test;
    if (n_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  task automatic fetch(input logic [23:0] a, input int ext_exp);
    int i;
    int e0;
    e0 = n_ext;
    @(posedge sys_clk);
    fetch_req <= '{1'b1, a};
    @(posedge sys_clk);
    fetch_req.req <= 1'b0;
    for (i = 0; i < 50 && fetch_rsp.valid !== 1'b1; i++)
      @(posedge sys_clk);
    if (fetch_rsp.valid !== 1'b1)
    begin
      n_errors++;
      finish_test();
    end
    `CHK(fetch_rsp.data, a ^ 24'ha5c3e1)
    for (i = 0; i < 50 && fetch_busy !== 1'b0; i++)
      @(posedge sys_clk);
    if (i >= 50)
    begin
      n_errors++;
      finish_test();
    end
    @(posedge sys_clk);
    `CHK(n_ext - e0, ext_exp)
  endtask : fetch
  task automatic s_bypass;
    fetch(24'h000010, 1);
    fetch(24'h000010, 1);
  endtask : s_bypass
  task automatic s_cache;
    core_status <= 24'h080000;
    fetch(24'h001005, 1);
    fetch(24'h001005, 0);
    fetch(24'h001006, 1);
  endtask : s_cache
  task automatic s_burst;
    chip_mode <= 8'h04;
    fetch(24'h002001, 3);
    fetch(24'h002003, 0);
    fetch(24'h002004, 4);
    fetch(24'h002007, 0);
  endtask : s_burst
  task automatic s_debug;
    int h;
    dbg_mode <= 1'b1;
    h = n_hit;
    fetch(24'h001005, 0);
    `CHK(n_hit - h, 1)
    sect_a = 8;
    for (int k = 0; k < 8; k++)
      if (dbg.mapped[k] === 1'b1 && dbg.tags[17*k+:17] === 17'h00020)
        sect_a = k;
    `CHK(sect_a < 8, 1'b1)
    dbg_sect <= sect_a[2:0];
    dbg_word <= 8'h05;
    repeat (2) @(posedge sys_clk);
    `CHK(dbg.vbit, 1'b1)
    dbg_word <= 8'h07;
    repeat (2) @(posedge sys_clk);
    `CHK(dbg.vbit, 1'b0)
  endtask : s_debug
  task automatic s_lock;
    logic [23:0] a;
    dbg_lock <= 8'hff;
    chip_mode <= 8'h00;
    fetch(24'h003000, 1);
    fetch(24'h003000, 1);
    dbg_lock <= 8'h01 << sect_a[2:0];
    for (int k = 0; k < 7; k++)
    begin
      a = 24'h004000 + 24'(k) * 24'h80;
      fetch(a, 1);
    end
    fetch(24'h001005, 0);
    // oldest unlocked sector is the one refilled first above
    `CHK(dbg.tags[17*dbg.lru +: 17], 17'h00080)
  endtask : s_lock
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    s_bypass();
    s_cache();
    s_burst();
    s_debug();
    s_lock();
    finish_test();
  end
endmodule : sic_cache_tb_top
